// file: core/ubt_pkg.sv
package ubt_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_BAUD_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RELOAD_LO  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RELOAD_HI  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FORMAT     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CTRL_STAT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DATA       = 8'h14;

  // ==========================================================================
  // field positions
  localparam int unsigned BGC_EN_BIT   = 6;
  localparam int unsigned CST_PERR_BIT = 6;
  localparam int unsigned CST_THRE_BIT = 5;
  localparam int unsigned CST_REN_BIT  = 4;
  localparam int unsigned CST_TBX_BIT  = 3;
  localparam int unsigned CST_RBX_BIT  = 2;
  localparam int unsigned CST_TI_BIT   = 1;
  localparam int unsigned CST_RI_BIT   = 0;

  // ==========================================================================
  // encodings and reset values
  localparam logic [1:0]  PS_DIV12 = 2'h0;
  localparam logic [1:0]  PS_DIV4  = 2'h1;
  localparam logic [1:0]  PS_DIV48 = 2'h2;
  localparam logic [1:0]  PS_DIV1  = 2'h3;
  localparam logic [5:0]  DIV_12   = 6'h0c;
  localparam logic [5:0]  DIV_4    = 6'h04;
  localparam logic [5:0]  DIV_48   = 6'h30;
  localparam logic [5:0]  DIV_1    = 6'h01;
  localparam logic [1:0]  PT_ODD   = 2'h0;
  localparam logic [1:0]  PT_EVEN  = 2'h1;
  localparam logic [1:0]  PT_MARK  = 2'h2;
  localparam logic [1:0]  PT_SPACE = 2'h3;
  localparam logic [1:0]  LEN_5    = 2'h0;
  localparam logic [1:0]  LEN_6    = 2'h1;
  localparam logic [1:0]  LEN_7    = 2'h2;
  localparam logic [15:0] TIMER_TOP    = 16'hffff;
  localparam logic [15:0] RELOAD_RST   = 16'h0000;
  localparam logic [2:0]  HALVES_BIT   = 3'h2;
  localparam logic [2:0]  HALVES_SHORT = 3'h2;
  localparam logic [2:0]  HALVES_MID   = 3'h3;
  localparam logic [2:0]  HALVES_LONG  = 3'h4;

  // ==========================================================================
  // types
  typedef struct packed {
    logic       multiproc_enable;
    logic       parity_enable;
    logic [1:0] parity_type_select;
    logic [1:0] char_len;
    logic       extra_bit_enable;
    logic       stop_long;
  } ubt_fmt_t;

  typedef enum logic [4:0] {
    SER_IDLE  = 5'h01,
    SER_START = 5'h02,
    SER_DATA  = 5'h04,
    SER_XTRA  = 5'h08,
    SER_STOP  = 5'h10
  } ubt_ser_st_t;

  // ==========================================================================
  // shared helpers
  function automatic logic [5:0] ps_div(input logic [1:0] sel);
    logic [5:0] d;
    d = DIV_1;
    if (sel == PS_DIV12) begin
      d = DIV_12;
    end else if (sel == PS_DIV4) begin
      d = DIV_4;
    end else if (sel == PS_DIV48) begin
      d = DIV_48;
    end
    return d;
  endfunction

  function automatic logic [2:0] last_bit(input logic [1:0] len);
    return 3'(len) + 3'h4;
  endfunction

  function automatic logic [7:0] len_mask(input logic [1:0] len);
    logic [7:0] m;
    m = 8'hff;
    if (len == LEN_5) begin
      m = 8'h1f;
    end else if (len == LEN_6) begin
      m = 8'h3f;
    end else if (len == LEN_7) begin
      m = 8'h7f;
    end
    return m;
  endfunction

  function automatic logic parity_bit(input logic [7:0] d, input ubt_fmt_t f);
    logic p;
    p = ^(d & len_mask(f.char_len));
    case (f.parity_type_select)
      PT_ODD:  parity_bit = ~p;
      PT_EVEN: parity_bit = p;
      PT_MARK: parity_bit = 1'b1;
      default: parity_bit = 1'b0;
    endcase
  endfunction

  function automatic logic has_slot(input ubt_fmt_t f);
    return f.parity_enable | f.extra_bit_enable;
  endfunction

  function automatic logic [2:0] stop_halves(input ubt_fmt_t f);
    logic [2:0] h;
    h = HALVES_SHORT;
    if (f.stop_long) begin
      // second stop needs 6 to 8 bits
      h = (f.char_len == LEN_5) ? HALVES_MID : HALVES_LONG;
    end
    return h;
  endfunction

endpackage

// file: core/ubt_top.sv
// What this block does
// - 16-bit baud timer, prescale 1/4/12/48
// - port runs only with generator enabled
// - timer counts up, reloads on overflow
// - reload built from high and low bytes
// - rate is clock/(65536-reload)/2/prescale
// - start low, data lsb first, stop high
// - five to eight data bits
// - even, odd, mark or space parity
// - stop one bit, or long
// - two stop bits only for 6-8 bits
// - parity enabled disables extra bit
// - full duplex transmit and receive
// - data write fills holding register
// - idle shifter takes byte at once
// - busy shifter leaves byte held
// - done flag set at stop start
// - extra slot carries software bit
// - parity appended after data
// - flags cleared only by software
// - data reads return received byte
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module ubt_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ubt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  output var  logic                      serial_tx_pin,
  input  wire logic                      serial_rx_pin
);

  // ==========================================================================
  // registers
  logic                  gen_en_q;
  logic [1:0]            baud_prescale_select_q;
  logic [7:0]            baud_reload_low_q;
  logic [7:0]            baud_reload_high_q;
  ubt_pkg::ubt_fmt_t     fmt_q;
  logic                  rx_en_q;
  logic                  tx_extra_bit_value_q;
  logic                  tx_done_flag_q;
  logic                  rx_done_flag_q;
  logic                  parity_err_q;
  logic                  rx_extra_q;
  logic [7:0]            rx_data_q;
  logic [7:0]            hold_q;
  logic                  hold_full_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [31:0]           prdata_q;
  logic [5:0]            pre_q;
  logic [15:0]           tmr_q;
  ubt_pkg::ubt_ser_st_t  tx_st_q;
  logic [2:0]            tx_hc_q;
  logic [2:0]            tx_bi_q;
  logic [7:0]            tx_sh_q;
  logic                  tx_xbit_q;
  logic                  tx_q;
  ubt_pkg::ubt_ser_st_t  rx_st_q;
  logic                  rx_hc_q;
  logic [2:0]            rx_bi_q;
  logic [7:0]            rx_sh_q;
  logic                  rx_xbit_q;
  logic                  rx_s1_q;
  logic                  rx_s2_q;

  logic [15:0]           reload;
  logic                  pre_tick;
  logic                  half_tick;
  logic                  acc;
  logic                  wr;
  logic                  mapped;
  logic [31:0]           rd_word;
  logic                  tx_load;
  logic                  tx_enter_stop;
  logic                  rx_store;
  logic [2:0]            tx_hc_nx;

  // ==========================================================================
  // apb slave: one wait state, access completes on the second access edge
  assign acc = psel & penable & pready_q;
  assign wr  = acc & pwrite;

  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    if (paddr == ubt_pkg::OFF_BAUD_CTRL) begin
      rd_word[ubt_pkg::BGC_EN_BIT] = gen_en_q;
      rd_word[1:0]                 = baud_prescale_select_q;
    end else if (paddr == ubt_pkg::OFF_RELOAD_LO) begin
      rd_word[7:0] = baud_reload_low_q;
    end else if (paddr == ubt_pkg::OFF_RELOAD_HI) begin
      rd_word[7:0] = baud_reload_high_q;
    end else if (paddr == ubt_pkg::OFF_FORMAT) begin
      rd_word[7:0] = fmt_q;
    end else if (paddr == ubt_pkg::OFF_CTRL_STAT) begin
      rd_word[ubt_pkg::CST_PERR_BIT] = parity_err_q;
      rd_word[ubt_pkg::CST_THRE_BIT] = ~hold_full_q;
      rd_word[ubt_pkg::CST_REN_BIT]  = rx_en_q;
      rd_word[ubt_pkg::CST_TBX_BIT]  = tx_extra_bit_value_q;
      rd_word[ubt_pkg::CST_RBX_BIT]  = rx_extra_q;
      rd_word[ubt_pkg::CST_TI_BIT]   = tx_done_flag_q;
      rd_word[ubt_pkg::CST_RI_BIT]   = rx_done_flag_q;
    end else if (paddr == ubt_pkg::OFF_DATA) begin
      rd_word[7:0] = rx_data_q;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (psel & penable & ~pready_q & ~pwrite) begin
        prdata_q <= rd_word;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // configuration writes; unmapped writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_en_q               <= 1'b0;
      baud_prescale_select_q <= ubt_pkg::PS_DIV12;
      baud_reload_low_q      <= ubt_pkg::RELOAD_RST[7:0];
      baud_reload_high_q     <= ubt_pkg::RELOAD_RST[15:8];
      fmt_q                  <= '0;
      rx_en_q                <= 1'b0;
      tx_extra_bit_value_q   <= 1'b0;
    end else if (wr) begin
      if (paddr == ubt_pkg::OFF_BAUD_CTRL) begin
        gen_en_q               <= pwdata[ubt_pkg::BGC_EN_BIT];
        baud_prescale_select_q <= pwdata[1:0];
      end else if (paddr == ubt_pkg::OFF_RELOAD_LO) begin
        baud_reload_low_q <= pwdata[7:0];
      end else if (paddr == ubt_pkg::OFF_RELOAD_HI) begin
        baud_reload_high_q <= pwdata[7:0];
      end else if (paddr == ubt_pkg::OFF_FORMAT) begin
        fmt_q <= ubt_pkg::ubt_fmt_t'(pwdata[7:0]);
      end else if (paddr == ubt_pkg::OFF_CTRL_STAT) begin
        rx_en_q              <= pwdata[ubt_pkg::CST_REN_BIT];
        tx_extra_bit_value_q <= pwdata[ubt_pkg::CST_TBX_BIT];
      end
    end
  end

  // ==========================================================================
  // status flags: hardware set wins over a software clear in the same cycle
  logic cst_wr;
  assign cst_wr = wr & (paddr == ubt_pkg::OFF_CTRL_STAT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_done_flag_q <= 1'b0;
      rx_done_flag_q <= 1'b0;
      parity_err_q   <= 1'b0;
      rx_extra_q     <= 1'b0;
    end else begin
      tx_done_flag_q <= tx_enter_stop |
                        (cst_wr ? pwdata[ubt_pkg::CST_TI_BIT] : tx_done_flag_q);
      rx_done_flag_q <= (rx_store & ~(fmt_q.multiproc_enable & ~rx_xbit_q)) |
                        (cst_wr ? pwdata[ubt_pkg::CST_RI_BIT] : rx_done_flag_q);
      parity_err_q   <= (rx_store & fmt_q.parity_enable &
                         (rx_xbit_q != ubt_pkg::parity_bit(rx_sh_q, fmt_q))) |
                        (cst_wr ? pwdata[ubt_pkg::CST_PERR_BIT] : parity_err_q);
      if (rx_store) begin
        rx_extra_q <= has_slot_rx() ? rx_xbit_q : rx_s2_q;
      end else if (cst_wr) begin
        rx_extra_q <= pwdata[ubt_pkg::CST_RBX_BIT];
      end
    end
  end

  function automatic logic has_slot_rx();
    return fmt_q.extra_bit_enable & ~fmt_q.parity_enable;
  endfunction

  // ==========================================================================
  // baud generator
  // reload from two bytes
  assign reload   = {baud_reload_high_q, baud_reload_low_q};
  assign pre_tick = gen_en_q & (pre_q == ubt_pkg::ps_div(baud_prescale_select_q) - 6'h01);
  assign half_tick = pre_tick & (tmr_q == ubt_pkg::TIMER_TOP);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 6'h00;
    // a new divide restarts the count, so it never sits past the new limit
    end else if (!gen_en_q || pre_tick || (wr && paddr == ubt_pkg::OFF_BAUD_CTRL)) begin
      pre_q <= 6'h00;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q <= ubt_pkg::RELOAD_RST;
    end else if (!gen_en_q || half_tick) begin
      tmr_q <= reload;
    end else if (pre_tick) begin
      tmr_q <= tmr_q + 16'h0001;
    end
  end

  // ==========================================================================
  // transmit holding register
  // idle shifter takes byte
  assign tx_load       = gen_en_q & (tx_st_q == ubt_pkg::SER_IDLE) & hold_full_q;
  assign tx_hc_nx      = tx_hc_q + 3'h1;
  assign tx_enter_stop = half_tick & (tx_hc_nx == ubt_pkg::HALVES_BIT) &
                         (((tx_st_q == ubt_pkg::SER_DATA) &
                           (tx_bi_q == ubt_pkg::last_bit(fmt_q.char_len)) &
                           ~ubt_pkg::has_slot(fmt_q)) |
                          (tx_st_q == ubt_pkg::SER_XTRA));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q      <= 8'h00;
      hold_full_q <= 1'b0;
    end else if (wr && paddr == ubt_pkg::OFF_DATA) begin
      hold_q      <= pwdata[7:0];
      hold_full_q <= 1'b1;
    end else if (tx_load) begin
      hold_full_q <= 1'b0;
    end
  end

  // ==========================================================================
  // transmit shifter, timed in half-bit ticks so 1.5 stop bits fall out
  // disabled generator halts port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q   <= ubt_pkg::SER_IDLE;
      tx_hc_q   <= 3'h0;
      tx_bi_q   <= 3'h0;
      tx_sh_q   <= 8'h00;
      tx_xbit_q <= 1'b0;
      tx_q      <= 1'b1;
    end else if (!gen_en_q) begin
      tx_st_q <= ubt_pkg::SER_IDLE;
      tx_q    <= 1'b1;
    end else begin
      case (tx_st_q)
        ubt_pkg::SER_IDLE: begin
          tx_q <= 1'b1;
          if (tx_load) begin
            tx_sh_q   <= hold_q;
            tx_xbit_q <= fmt_q.parity_enable ? ubt_pkg::parity_bit(hold_q, fmt_q)
                                             : tx_extra_bit_value_q;
            tx_hc_q   <= 3'h0;
            tx_q      <= 1'b0;
            tx_st_q   <= ubt_pkg::SER_START;
          end
        end
        ubt_pkg::SER_START: begin
          if (half_tick) begin
            tx_hc_q <= tx_hc_nx;
            if (tx_hc_nx == ubt_pkg::HALVES_BIT) begin
              tx_hc_q <= 3'h0;
              tx_bi_q <= 3'h0;
              tx_q    <= tx_sh_q[0];
              tx_st_q <= ubt_pkg::SER_DATA;
            end
          end
        end
        ubt_pkg::SER_DATA: begin
          if (half_tick) begin
            tx_hc_q <= tx_hc_nx;
            if (tx_hc_nx == ubt_pkg::HALVES_BIT) begin
              tx_hc_q <= 3'h0;
              if (tx_bi_q != ubt_pkg::last_bit(fmt_q.char_len)) begin
                tx_bi_q <= tx_bi_q + 3'h1;
                tx_sh_q <= tx_sh_q >> 1;
                tx_q    <= tx_sh_q[1];
              end else if (ubt_pkg::has_slot(fmt_q)) begin
                tx_q    <= tx_xbit_q;
                tx_st_q <= ubt_pkg::SER_XTRA;
              end else begin
                tx_q    <= 1'b1;
                tx_st_q <= ubt_pkg::SER_STOP;
              end
            end
          end
        end
        ubt_pkg::SER_XTRA: begin
          if (half_tick) begin
            tx_hc_q <= tx_hc_nx;
            if (tx_hc_nx == ubt_pkg::HALVES_BIT) begin
              tx_hc_q <= 3'h0;
              tx_q    <= 1'b1;
              tx_st_q <= ubt_pkg::SER_STOP;
            end
          end
        end
        default: begin
          if (half_tick) begin
            tx_hc_q <= tx_hc_nx;
            if (tx_hc_nx == ubt_pkg::stop_halves(fmt_q)) begin
              tx_hc_q <= 3'h0;
              tx_st_q <= ubt_pkg::SER_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign serial_tx_pin = tx_q;

  // ==========================================================================
  // receiver: one byte deep, sampled on half-bit ticks, runs beside transmit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= serial_rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end

  // framing errors are dropped silently; stop must read high to store
  assign rx_store = half_tick & (rx_st_q == ubt_pkg::SER_STOP) & rx_hc_q & rx_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q   <= ubt_pkg::SER_IDLE;
      rx_hc_q   <= 1'b0;
      rx_bi_q   <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_xbit_q <= 1'b0;
      rx_data_q <= 8'h00;
    end else if (!gen_en_q || !rx_en_q) begin
      rx_st_q <= ubt_pkg::SER_IDLE;
    end else if (half_tick) begin
      rx_hc_q <= ~rx_hc_q;
      case (rx_st_q)
        ubt_pkg::SER_IDLE: begin
          rx_hc_q <= 1'b0;
          if (!rx_s2_q) begin
            rx_st_q <= ubt_pkg::SER_START;
          end
        end
        ubt_pkg::SER_START: begin
          rx_hc_q <= 1'b0;
          rx_bi_q <= 3'h0;
          rx_sh_q <= 8'h00;
          rx_st_q <= rx_s2_q ? ubt_pkg::SER_IDLE : ubt_pkg::SER_DATA;
        end
        ubt_pkg::SER_DATA: begin
          if (rx_hc_q) begin
            rx_sh_q[rx_bi_q] <= rx_s2_q;
            rx_bi_q          <= rx_bi_q + 3'h1;
            if (rx_bi_q == ubt_pkg::last_bit(fmt_q.char_len)) begin
              rx_st_q <= ubt_pkg::has_slot(fmt_q) ? ubt_pkg::SER_XTRA : ubt_pkg::SER_STOP;
            end
          end
        end
        ubt_pkg::SER_XTRA: begin
          if (rx_hc_q) begin
            rx_xbit_q <= rx_s2_q;
            rx_st_q   <= ubt_pkg::SER_STOP;
          end
        end
        default: begin
          if (rx_hc_q) begin
            if (rx_s2_q) begin
              rx_data_q <= rx_sh_q;
            end
            rx_st_q <= ubt_pkg::SER_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // assertions
  sequence s_data_write;
    wr && paddr == ubt_pkg::OFF_DATA;
  endsequence

  sequence s_load_then_start;
    hold_full_q ##1 (tx_st_q == ubt_pkg::SER_START && !tx_q);
  endsequence

  a_tx_line_idle: assert property (@(posedge pclk) disable iff (!presetn)
    tx_st_q == ubt_pkg::SER_IDLE |-> serial_tx_pin)
    else $error("tx line not high while idle");

  a_start_bit_low: assert property (@(posedge pclk) disable iff (!presetn)
    tx_st_q == ubt_pkg::SER_START |-> !serial_tx_pin)
    else $error("start bit not low");

  a_idle_load_now: assert property (@(posedge pclk) disable iff (!presetn)
    (s_data_write and (tx_st_q == ubt_pkg::SER_IDLE && gen_en_q && !hold_full_q))
    ##1 gen_en_q |-> s_load_then_start)
    else $error("idle shifter did not take held byte");

  a_holding_filled: assert property (@(posedge pclk) disable iff (!presetn)
    s_data_write |=> hold_full_q)
    else $error("write did not fill holding register");

  a_busy_keeps_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_st_q != ubt_pkg::SER_IDLE && hold_full_q) |=> hold_full_q)
    else $error("held byte left during transmission");

  a_done_at_stop: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_st_q == ubt_pkg::SER_STOP && $past(tx_st_q) != ubt_pkg::SER_STOP) |-> tx_done_flag_q)
    else $error("done flag missing at stop start");

  a_timer_reload: assert property (@(posedge pclk) disable iff (!presetn)
    half_tick |=> tmr_q == $past(reload))
    else $error("timer not reloaded on overflow");

  a_timer_step: assert property (@(posedge pclk) disable iff (!presetn)
    (pre_tick && tmr_q != ubt_pkg::TIMER_TOP) |=> tmr_q == $past(tmr_q) + 16'h0001)
    else $error("timer did not step by one");

  a_prescale_range: assert property (@(posedge pclk) disable iff (!presetn)
    gen_en_q |-> pre_q < ubt_pkg::ps_div(baud_prescale_select_q))
    else $error("prescaler beyond divide factor");

  a_disable_halts: assert property (@(posedge pclk) disable iff (!presetn)
    !gen_en_q |=> tx_st_q == ubt_pkg::SER_IDLE && serial_tx_pin)
    else $error("transmitter ran with generator off");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");

endmodule

`default_nettype wire

// file: verif/ubt_link_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// remote serial device: samples our line mid-bit and answers with its own frame
module ubt_link_model (
  input  wire logic        pclk,
  input  wire logic        line_in,
  input  wire logic [31:0] half,
  input  wire logic [31:0] nsamp,
  input  wire logic [11:0] reply,
  output var  logic        line_out,
  output var  logic [11:0] frame_q,
  output var  int          count
);
  logic [11:0] f;
  initial begin
    count = 0;
    frame_q = '0;
    forever begin
      @(negedge line_in);
      f = '0;
      // start may last one or two halves, so sample past its longest end
      repeat (2 * half + half / 2) @(negedge pclk);
      for (int i = 0; i < nsamp; i++) begin
        f[i] = line_in;
        if (i < nsamp - 1) repeat (2 * half) @(negedge pclk);
      end
      frame_q = f;
      count++;
    end
  end
  // answer goes out while our frame is still arriving; whole bit
  // times, so the far receiver sees exact bits whatever the timer phase
  initial begin
    line_out = 1'b1;
    forever begin
      @(negedge line_in);
      @(negedge pclk);
      line_out = 1'b0;
      repeat (2 * half) @(negedge pclk);
      for (int i = 0; i < nsamp; i++) begin
        line_out = reply[i];
        repeat (2 * half) @(negedge pclk);
      end
      line_out = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verif/ubt_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
// ==========================================================================
module ubt_top_tb;
  typedef struct packed {
    logic [1:0]  ps;
    logic [15:0] rl;
    logic [7:0]  fmt;
    logic        tbx;
    logic [7:0]  d;
    logic [7:0]  h;
    logic [3:0]  n;
    logic [11:0] want;
  } ubt_row_t;
  // bit times kept at sixteen clocks or slower
  // point-to-point link: multiproc enable stays clear in every row
  localparam ubt_row_t ROWS [6] = '{
    '{2'h3, 16'hfff8, 8'h4e, 1'h0, 8'ha5, 8'h08, 4'ha, 12'h3a5},
    '{2'h1, 16'hfffe, 8'h58, 1'h0, 8'h13, 8'h08, 4'h9, 12'h193},
    '{2'h0, 16'hffff, 8'h64, 1'h0, 8'hea, 8'h0c, 4'h8, 12'h0ea},
    '{2'h2, 16'hffff, 8'h70, 1'h0, 8'h1f, 8'h30, 4'h7, 12'h05f},
    '{2'h3, 16'hfff0, 8'h0e, 1'h1, 8'h3c, 8'h10, 4'ha, 12'h33c},
    '{2'h3, 16'hfff0, 8'h03, 1'h0, 8'h0a, 8'h10, 4'h7, 12'h04a}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tx, rx, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] frame;
  int          errors, checked, half, nsamp, count, c0;
  ubt_row_t    r;

  ubt_top ubt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_tx_pin(tx), .serial_rx_pin(rx));
  ubt_link_model ubt_link_model_inst (.pclk(pclk), .line_in(tx), .half(half), .nsamp(nsamp),
    .reply(r.want), .line_out(rx), .frame_q(frame), .count(count));

  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    @(posedge pclk);
  endtask

  task automatic wait_frames(input int k);
    int n;
    n = 0;
    while (count < c0 + k && n < 8000) begin
      @(posedge pclk);
      n++;
    end
    if (count < c0 + k) begin
      errors++;
      stop_test();
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {errors, checked, c0, half, nsamp} = {32'd0, 32'd0, 32'd0, 32'd8, 32'd10};
    repeat (2) @(posedge pclk);
    `CHK("tx_reset", 1'b1, tx)
    presetn <= 1'b1;
    apb(1'b0, ubt_pkg::OFF_CTRL_STAT, 32'h0);
    `CHK("stat_reset", 32'h20, rd)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 1'b1, err)
    $display("reset done");
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      // reload before enable, else the timer starts its first count from zero
      apb(1'b1, ubt_pkg::OFF_RELOAD_LO, 32'(r.rl[7:0]));
      apb(1'b1, ubt_pkg::OFF_RELOAD_HI, 32'(r.rl[15:8]));
      apb(1'b1, ubt_pkg::OFF_BAUD_CTRL, 32'h40 | 32'(r.ps));
      apb(1'b1, ubt_pkg::OFF_FORMAT, 32'(r.fmt));
      // software clears the flags; receiver on for the answer
      apb(1'b1, ubt_pkg::OFF_CTRL_STAT, 32'h10 | (32'(r.tbx) << 3));
      half = int'(r.h);
      nsamp = int'(r.n);
      c0 = count;
      apb(1'b1, ubt_pkg::OFF_DATA, 32'(r.d));
      wait_frames(1);
      `CHK("frame", r.want, frame)
      // let the answer frame finish and land in the receiver
      repeat (4 * half) @(posedge pclk);
      apb(1'b0, ubt_pkg::OFF_CTRL_STAT, 32'h0);
      `CHK("done_empty", 32'h23, rd & 32'h63)
      apb(1'b0, ubt_pkg::OFF_DATA, 32'h0);
      `CHK("data_read", 32'(r.d) & (32'hff >> (10 - int'(r.n))), rd)
      $display("row %0d done", i);
    end
    c0 = count;
    apb(1'b1, ubt_pkg::OFF_DATA, 32'h0a);
    // second byte goes in once the first has left the holding register
    apb(1'b1, ubt_pkg::OFF_DATA, 32'h11);
    apb(1'b0, ubt_pkg::OFF_CTRL_STAT, 32'h0);
    `CHK("held", 32'h0, rd & 32'h20)
    wait_frames(1);
    `CHK("first", 12'h04a, frame)
    wait_frames(2);
    `CHK("second", 12'h051, frame)
    $display("back to back done");
    apb(1'b1, ubt_pkg::OFF_BAUD_CTRL, 32'h03);
    c0 = count;
    apb(1'b1, ubt_pkg::OFF_DATA, 32'h55);
    repeat (200) @(posedge pclk);
    `CHK("off_idle", 1'b1, tx)
    `CHK("off_count", c0, count)
    apb(1'b1, ubt_pkg::OFF_BAUD_CTRL, 32'h43);
    wait_frames(1);
    `CHK("resumed", 12'h055, frame)
    $display("generator off done");
    stop_test();
  end
endmodule
`default_nettype wire
